/* design/ovd_pkg.sv */
package ovd_pkg;

    // Register byte addresses
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hf803828c;
    localparam logic [31:0] IRQ_DISABLE_ADDR = 32'hf8038290;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hf8038294;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hf8038298;
    localparam logic [31:0] DESC_HEAD_ADDR = 32'hf803829c;
    localparam logic [31:0] FRAME_BASE_ADDR = 32'hf80382a0;
    localparam logic [31:0] DMA_CONTROL_ADDR = 32'hf80382a4;

    // Values after reset
    localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] DESC_HEAD_RESET = 32'h00000000;
    localparam logic [31:0] FRAME_BASE_RESET = 32'h00000000;
    localparam logic [5:0] DMA_CONTROL_RESET = 6'h00;

    // Event field positions in mask and status
    localparam int BASE_EVENT_LSB = 2;
    localparam int CHROMA_U_EVENT_LSB = 10;
    localparam int CHROMA_V_EVENT_LSB = 18;
    localparam int EVENT_COUNT = 5;
    localparam logic [31:0] IRQ_VALID_BITS = 32'h007c7c7c;

    // Event order inside each five-bit group
    localparam int EV_TRANSFER_END = 0;
    localparam int EV_DESCRIPTOR_LOADED = 1;
    localparam int EV_HEAD_LOADED = 2;
    localparam int EV_LIST_END = 3;
    localparam int EV_OVERFLOW = 4;

    // Head pointer keeps bits 31:2 only
    localparam logic [31:0] DESC_HEAD_BITS = 32'hfffffffc;

    // Control register fields
    localparam int CTL_DESCRIPTOR_FETCH_ENABLE = 0;
    localparam int CTL_LOOKUP_TABLE_FETCH_ENABLE = 1;
    localparam int CTL_TRANSFER_END_IRQ = 2;
    localparam int CTL_DESCRIPTOR_LOADED_IRQ = 3;
    localparam int CTL_HEAD_ADDED_IRQ = 4;
    localparam int CTL_LIST_END_IRQ = 5;
    localparam int CTL_WIDTH = 6;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

/* design/ovd_irq_regs.sv */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Writing one to a disable bit clears that source's mask bit; zero leaves it.
// - Read-only mask register reads one for each enabled interrupt source.
// - Base sources at bits 2-6, U/UV at 10-14, V at 18-22.
// - Transfer-end flag sets on end of transfer, clears when status is read.
// - Descriptor-loaded flag sets after any descriptor fetch, clears on status read.
// - Head-loaded flag sets after head descriptor fetch, clears on status read.
// - End-of-list flag sets at list end, clears on status read.
// - Overflow flag sets on pixel overflow, clears on status read.
// - U/UV and V streams have their own independent five event flags.
// - Head pointer register is word aligned, bits 1:0 reserved, resets to zero.
// - Frame buffer base is a 32-bit read-write register, used as start address.
// - Control bits: fetch enables at 0 and 1, interrupt controls at 2-5.
// - Descriptors are fetched only while descriptor fetch enable is one.
// - Lookup-table fetches happen only while lookup-table fetch enable is one.
// - Transfer-end, descriptor-loaded, head-added controls: zero enables, one disables.
// - End-of-list control: one enables, zero disables.
module ovd_irq_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [4:0] base_events,
    input wire logic [4:0] chroma_u_events,
    input wire logic [4:0] chroma_v_events,
    input wire logic descriptor_fetch_req,
    input wire logic lookup_table_fetch_req,
    output logic descriptor_fetch_go,
    output logic lookup_table_fetch_go,
    output logic descriptor_fetch_enable,
    output logic lookup_table_fetch_enable,
    output logic [3:0] desc_irq_enables,
    output logic [31:0] descriptor_head,
    output logic [31:0] frame_base,
    output logic irq
);

    typedef struct packed {
        logic [31:0] stat;
        logic [31:0] mask;
        logic [31:0] head;
        logic [31:0] fbase;
        logic [5:0] ctrl;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic irq;
        logic desc_go;
        logic lut_go;
        logic [3:0] dirq_en;
    } ovd_state_s;

    ovd_state_s s_q;
    ovd_state_s s_d;

    logic addr_take;
    logic rd_take;
    logic [31:0] ev_all;

    // Places the three five-bit event groups at their status positions
    function automatic logic [31:0] ovd_place_events(
        input logic [4:0] b,
        input logic [4:0] u,
        input logic [4:0] v
    );
        logic [31:0] r;
        r = 32'h00000000;
        r[ovd_pkg::BASE_EVENT_LSB +: ovd_pkg::EVENT_COUNT] = b;
        r[ovd_pkg::CHROMA_U_EVENT_LSB +: ovd_pkg::EVENT_COUNT] = u;
        r[ovd_pkg::CHROMA_V_EVENT_LSB +: ovd_pkg::EVENT_COUNT] = v;
        return r;
    endfunction

    // Read multiplexer; unmapped and write-only addresses read zero
    function automatic logic [31:0] ovd_read_mux(
        input logic [31:0] a,
        input logic [31:0] mask,
        input logic [31:0] stat,
        input logic [31:0] head,
        input logic [31:0] fbase,
        input logic [5:0] ctrl
    );
        logic [31:0] r;
        r = 32'h00000000;
        if (a == ovd_pkg::IRQ_MASK_ADDR) begin
            r = mask;
        end else if (a == ovd_pkg::IRQ_STATUS_ADDR) begin
            r = stat;
        end else if (a == ovd_pkg::DESC_HEAD_ADDR) begin
            r = head;
        end else if (a == ovd_pkg::FRAME_BASE_ADDR) begin
            r = fbase;
        end else if (a == ovd_pkg::DMA_CONTROL_ADDR) begin
            r = {26'h0000000, ctrl};
        end
        return r;
    endfunction

    assign addr_take = hsel && hready && htrans[1] && (hsize == ovd_pkg::HSIZE_WORD);
    assign rd_take = addr_take && !hwrite;
    assign ev_all = ovd_place_events(base_events, chroma_u_events, chroma_v_events);

    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.resp = ovd_pkg::HRESP_OKAY;

        // Data phase of a write taken on the previous edge
        if (s_q.wr_pend) begin
            if (s_q.wr_addr == ovd_pkg::IRQ_ENABLE_ADDR) begin
                s_d.mask = s_q.mask | (hwdata & ovd_pkg::IRQ_VALID_BITS);
            end else if (s_q.wr_addr == ovd_pkg::IRQ_DISABLE_ADDR) begin
                s_d.mask = s_q.mask & ~hwdata;
            end else if (s_q.wr_addr == ovd_pkg::DESC_HEAD_ADDR) begin
                s_d.head = hwdata & ovd_pkg::DESC_HEAD_BITS;
            end else if (s_q.wr_addr == ovd_pkg::FRAME_BASE_ADDR) begin
                s_d.fbase = hwdata;
            end else if (s_q.wr_addr == ovd_pkg::DMA_CONTROL_ADDR) begin
                s_d.ctrl = hwdata[ovd_pkg::CTL_WIDTH-1:0];
            end
        end

        // Address phase; read data forwards a write landing in the same cycle
        s_d.wr_pend = addr_take && hwrite;
        if (addr_take) begin
            s_d.wr_addr = haddr;
        end
        if (rd_take) begin
            s_d.rdata = ovd_read_mux(haddr, s_d.mask, s_q.stat, s_d.head, s_d.fbase,
                s_d.ctrl);
        end

        // Read clears what was returned; new events survive the clear
        s_d.stat = s_q.stat;
        if (rd_take && haddr == ovd_pkg::IRQ_STATUS_ADDR) begin
            s_d.stat = ovd_pkg::IRQ_STATUS_RESET;
        end
        s_d.stat = s_d.stat | ev_all;

        s_d.irq = |(s_d.stat & s_d.mask);

        // Fetch grants follow the enable bits
        s_d.desc_go = descriptor_fetch_req
            && s_q.ctrl[ovd_pkg::CTL_DESCRIPTOR_FETCH_ENABLE];
        s_d.lut_go = lookup_table_fetch_req
            && s_q.ctrl[ovd_pkg::CTL_LOOKUP_TABLE_FETCH_ENABLE];

        // Active-high view of the descriptor-level interrupt controls
        s_d.dirq_en[0] = !s_d.ctrl[ovd_pkg::CTL_TRANSFER_END_IRQ];
        s_d.dirq_en[1] = !s_d.ctrl[ovd_pkg::CTL_DESCRIPTOR_LOADED_IRQ];
        s_d.dirq_en[2] = !s_d.ctrl[ovd_pkg::CTL_HEAD_ADDED_IRQ];
        s_d.dirq_en[3] = s_d.ctrl[ovd_pkg::CTL_LIST_END_IRQ];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.stat <= ovd_pkg::IRQ_STATUS_RESET;
            s_q.mask <= ovd_pkg::IRQ_MASK_RESET;
            s_q.head <= ovd_pkg::DESC_HEAD_RESET;
            s_q.fbase <= ovd_pkg::FRAME_BASE_RESET;
            s_q.ctrl <= ovd_pkg::DMA_CONTROL_RESET;
            s_q.wr_pend <= 1'b0;
            s_q.wr_addr <= 32'h00000000;
            s_q.rdata <= 32'h00000000;
            s_q.ready <= 1'b1;
            s_q.resp <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.desc_go <= 1'b0;
            s_q.lut_go <= 1'b0;
            s_q.dirq_en <= 4'h7;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.ready;
    assign hresp = s_q.resp;
    assign hrdata = s_q.rdata;
    assign irq = s_q.irq;
    assign descriptor_fetch_go = s_q.desc_go;
    assign lookup_table_fetch_go = s_q.lut_go;
    assign descriptor_fetch_enable = s_q.ctrl[ovd_pkg::CTL_DESCRIPTOR_FETCH_ENABLE];
    assign lookup_table_fetch_enable = s_q.ctrl[ovd_pkg::CTL_LOOKUP_TABLE_FETCH_ENABLE];
    assign desc_irq_enables = s_q.dirq_en;
    assign descriptor_head = s_q.head;
    assign frame_base = s_q.fbase;

    default clocking ovd_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_disable_clears_mask: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::IRQ_DISABLE_ADDR
        |=> (s_q.mask & $past(hwdata)) == 32'h00000000
            && (s_q.mask | $past(hwdata)) == ($past(s_q.mask) | $past(hwdata)))
    else $error("Disable write did not clear exactly the written mask bits");

    chk_mask_read_value: assert property (
        clk_en && rd_take && haddr == ovd_pkg::IRQ_MASK_ADDR && !s_q.wr_pend
        |=> hrdata == $past(s_q.mask))
    else $error("Mask read returned a value other than the mask");

    chk_status_layout_bits: assert property (
        (s_q.stat & ~ovd_pkg::IRQ_VALID_BITS) == 32'h00000000
        && (s_q.mask & ~ovd_pkg::IRQ_VALID_BITS) == 32'h00000000)
    else $error("Mask or status bit set outside the event fields");

    chk_event_sets_flag: assert property (
        clk_en && ev_all != 32'h00000000
        |=> (s_q.stat & $past(ev_all)) == $past(ev_all))
    else $error("Event did not set its status flag");

    chk_status_read_clears: assert property (
        clk_en && rd_take && haddr == ovd_pkg::IRQ_STATUS_ADDR && ev_all == 32'h00000000
        |=> s_q.stat == 32'h00000000 && hrdata == $past(s_q.stat))
    else $error("Status read did not return and clear the flags");

    chk_read_keeps_event: assert property (
        clk_en && rd_take && haddr == ovd_pkg::IRQ_STATUS_ADDR
        |=> s_q.stat == $past(ev_all) && hrdata == $past(s_q.stat))
    else $error("Event lost in the cycle of a status read");

    chk_head_word_aligned: assert property (
        descriptor_head[1:0] == 2'b00)
    else $error("Head pointer low bits not zero");

    chk_frame_base_write: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::FRAME_BASE_ADDR
        |=> frame_base == $past(hwdata))
    else $error("Frame base did not take the written word");

    chk_control_fetch_bits: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::DMA_CONTROL_ADDR
        |=> descriptor_fetch_enable == $past(hwdata[0])
            && lookup_table_fetch_enable == $past(hwdata[1]))
    else $error("Control fetch enables not at bits 0 and 1");

    chk_descriptor_fetch_gate: assert property (
        clk_en && !descriptor_fetch_enable |=> !descriptor_fetch_go)
    else $error("Descriptor fetch granted while disabled");

    chk_lookup_fetch_gate: assert property (
        clk_en ##1 lookup_table_fetch_go
        |-> $past(lookup_table_fetch_req) && $past(lookup_table_fetch_enable))
    else $error("Lookup-table fetch granted without request and enable");

    chk_low_active_ctls: assert property (
        desc_irq_enables[2:0] == ~s_q.ctrl[4:2])
    else $error("Descriptor-level enable polarity wrong");

    chk_list_end_ctl: assert property (
        desc_irq_enables[3] == s_q.ctrl[ovd_pkg::CTL_LIST_END_IRQ])
    else $error("End-of-list enable polarity wrong");

    chk_irq_level_out: assert property (
        irq == |(s_q.stat & s_q.mask))
    else $error("Interrupt output disagrees with status and mask");

    chk_transfer_end_set: assert property (
        clk_en && base_events[ovd_pkg::EV_TRANSFER_END]
        |=> s_q.stat[ovd_pkg::BASE_EVENT_LSB + ovd_pkg::EV_TRANSFER_END])
    else $error("Transfer-end event did not set its flag");

    chk_descr_loaded_set: assert property (
        clk_en && base_events[ovd_pkg::EV_DESCRIPTOR_LOADED]
        |=> s_q.stat[ovd_pkg::BASE_EVENT_LSB + ovd_pkg::EV_DESCRIPTOR_LOADED])
    else $error("Descriptor-loaded event did not set its flag");

    chk_head_loaded_set: assert property (
        clk_en && base_events[ovd_pkg::EV_HEAD_LOADED]
        |=> s_q.stat[ovd_pkg::BASE_EVENT_LSB + ovd_pkg::EV_HEAD_LOADED])
    else $error("Head-loaded event did not set its flag");

    chk_list_end_set: assert property (
        clk_en && base_events[ovd_pkg::EV_LIST_END]
        |=> s_q.stat[ovd_pkg::BASE_EVENT_LSB + ovd_pkg::EV_LIST_END])
    else $error("End-of-list event did not set its flag");

    chk_overflow_set: assert property (
        clk_en && base_events[ovd_pkg::EV_OVERFLOW]
        |=> s_q.stat[ovd_pkg::BASE_EVENT_LSB + ovd_pkg::EV_OVERFLOW])
    else $error("Overflow event did not set its flag");

    chk_chroma_u_group: assert property (
        clk_en && chroma_u_events != 5'h00
        |=> (s_q.stat[ovd_pkg::CHROMA_U_EVENT_LSB +: ovd_pkg::EVENT_COUNT]
            & $past(chroma_u_events)) == $past(chroma_u_events))
    else $error("U/UV event did not set its own flag");

    chk_chroma_v_group: assert property (
        clk_en && chroma_v_events != 5'h00
        |=> (s_q.stat[ovd_pkg::CHROMA_V_EVENT_LSB +: ovd_pkg::EVENT_COUNT]
            & $past(chroma_v_events)) == $past(chroma_v_events))
    else $error("V event did not set its own flag");

    chk_mask_holds_idle: assert property (
        clk_en && !(s_q.wr_pend && (s_q.wr_addr == ovd_pkg::IRQ_ENABLE_ADDR
            || s_q.wr_addr == ovd_pkg::IRQ_DISABLE_ADDR))
        |=> s_q.mask == $past(s_q.mask))
    else $error("Mask changed without an enable or disable write");

    chk_enable_sets_mask: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::IRQ_ENABLE_ADDR
        |=> s_q.mask == ($past(s_q.mask) | ($past(hwdata) & ovd_pkg::IRQ_VALID_BITS)))
    else $error("Enable write did not set exactly the written mask bits");

    chk_status_sticky: assert property (
        clk_en && !(rd_take && haddr == ovd_pkg::IRQ_STATUS_ADDR)
        |=> s_q.stat == ($past(s_q.stat) | $past(ev_all)))
    else $error("Status flag changed without an event or a status read");

    chk_head_write_value: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::DESC_HEAD_ADDR
        |=> descriptor_head == {$past(hwdata[31:2]), 2'b00})
    else $error("Head pointer did not take the written word address");

    chk_head_holds: assert property (
        clk_en && !(s_q.wr_pend && s_q.wr_addr == ovd_pkg::DESC_HEAD_ADDR)
        |=> descriptor_head == $past(descriptor_head))
    else $error("Head pointer changed without a write");

    chk_head_read_value: assert property (
        clk_en && rd_take && haddr == ovd_pkg::DESC_HEAD_ADDR && !s_q.wr_pend
        |=> hrdata == $past(descriptor_head))
    else $error("Head read returned a value other than the head pointer");

    chk_frame_base_holds: assert property (
        clk_en && !(s_q.wr_pend && s_q.wr_addr == ovd_pkg::FRAME_BASE_ADDR)
        |=> frame_base == $past(frame_base))
    else $error("Frame base changed without a write");

    chk_frame_base_read: assert property (
        clk_en && rd_take && haddr == ovd_pkg::FRAME_BASE_ADDR && !s_q.wr_pend
        |=> hrdata == $past(frame_base))
    else $error("Frame base read returned a value other than the frame base");

    chk_control_irq_bits: assert property (
        clk_en && s_q.wr_pend && s_q.wr_addr == ovd_pkg::DMA_CONTROL_ADDR
        |=> s_q.ctrl[ovd_pkg::CTL_LIST_END_IRQ:ovd_pkg::CTL_TRANSFER_END_IRQ]
            == $past(hwdata[ovd_pkg::CTL_LIST_END_IRQ:ovd_pkg::CTL_TRANSFER_END_IRQ]))
    else $error("Control interrupt bits not at bits 2 to 5");

    chk_control_holds: assert property (
        clk_en && !(s_q.wr_pend && s_q.wr_addr == ovd_pkg::DMA_CONTROL_ADDR)
        |=> s_q.ctrl == $past(s_q.ctrl))
    else $error("Control bits changed without a write");

    chk_control_read_value: assert property (
        clk_en && rd_take && haddr == ovd_pkg::DMA_CONTROL_ADDR && !s_q.wr_pend
        |=> hrdata == {26'h0000000, $past(s_q.ctrl)})
    else $error("Control read returned a value other than the control bits");

    chk_descriptor_fetch_grant: assert property (
        clk_en && descriptor_fetch_req && descriptor_fetch_enable |=> descriptor_fetch_go)
    else $error("Enabled descriptor fetch request not granted");

    chk_lookup_fetch_block: assert property (
        clk_en && !lookup_table_fetch_enable |=> !lookup_table_fetch_go)
    else $error("Lookup-table fetch granted while disabled");

    chk_lookup_fetch_grant: assert property (
        clk_en && lookup_table_fetch_req && lookup_table_fetch_enable
        |=> lookup_table_fetch_go)
    else $error("Enabled lookup-table fetch request not granted");

    chk_irq_clears_with_status: assert property (
        clk_en && rd_take && haddr == ovd_pkg::IRQ_STATUS_ADDR && ev_all == 32'h00000000
        |=> !irq)
    else $error("Interrupt output stayed high after a status read");

endmodule // ovd_irq_regs

/* test/ovd_mem_model.sv */
`timescale 1ns/1ps
module ovd_mem_model #(
    parameter int LATENCY = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic descriptor_fetch_go,
    output logic [4:0] mem_events
);
    logic [7:0] pipe_q;
    // A descriptor read returns LATENCY cycles after the fetch grant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pipe_q <= 8'h00;
        end else begin
            pipe_q <= {pipe_q[6:0], descriptor_fetch_go};
        end
    end
    assign mem_events = {3'h0, pipe_q[LATENCY-1], 1'b0};
endmodule // ovd_mem_model

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [14:0] ev_q = 15'h0;
    logic [14:0] ev_pend = 15'h0;
    logic dreq = 1'b0;
    logic lreq = 1'b0;
    logic hreadyout, hresp, dgo, lgo, den, len, irq;
    logic [31:0] hrdata, head, fbase, r;
    logic [3:0] irq_en;
    logic [4:0] mem_ev;
    int fails = 0;
    int num_checks = 0;

    ovd_irq_regs dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .base_events(ev_q[4:0] | mem_ev), .chroma_u_events(ev_q[9:5]),
        .chroma_v_events(ev_q[14:10]), .descriptor_fetch_req(dreq),
        .lookup_table_fetch_req(lreq), .descriptor_fetch_go(dgo),
        .lookup_table_fetch_go(lgo), .descriptor_fetch_enable(den),
        .lookup_table_fetch_enable(len), .desc_irq_enables(irq_en),
        .descriptor_head(head), .frame_base(fbase), .irq(irq));
    ovd_mem_model #(.LATENCY(3)) mem (.hclk(hclk), .hresetn(hresetn),
        .descriptor_fetch_go(dgo), .mem_events(mem_ev));

    initial begin
        forever #25 hclk = ~hclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Single word transfer; pending events ride on the address phase edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        ev_q <= ev_pend;
        ev_pend = 15'h0;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        ev_q <= 15'h0;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk({28'h0, irq_en}, 32'h7);
        rd(ovd_pkg::IRQ_MASK_ADDR, 32'h0);
        rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h0);
        rd(ovd_pkg::DESC_HEAD_ADDR, 32'h0);
        rd(ovd_pkg::FRAME_BASE_ADDR, 32'h0);
        rd(ovd_pkg::DMA_CONTROL_ADDR, 32'h0);
        xfer(1'b1, ovd_pkg::DESC_HEAD_ADDR, 32'h1234567f);
        rd(ovd_pkg::DESC_HEAD_ADDR, 32'h1234567c);
        chk(head, 32'h1234567c);
        xfer(1'b1, ovd_pkg::FRAME_BASE_ADDR, 32'hdeadbeef);
        rd(ovd_pkg::FRAME_BASE_ADDR, 32'hdeadbeef);
        chk(fbase, 32'hdeadbeef);
        xfer(1'b1, ovd_pkg::DMA_CONTROL_ADDR, 32'h0000003c);
        rd(ovd_pkg::DMA_CONTROL_ADDR, 32'h3c);
        chk({28'h0, irq_en}, 32'h8);
        for (int e = 0; e < 2; e++) begin
            xfer(1'b1, ovd_pkg::DMA_CONTROL_ADDR, e ? 32'h0 : 32'h3);
            // The write lands at the edge that ends its data phase
            @(posedge hclk);
            chk({30'h0, len, den}, e ? 32'h0 : 32'h3);
            dreq <= 1'b1;
            lreq <= 1'b1;
            @(posedge hclk);
            dreq <= 1'b0;
            lreq <= 1'b0;
            #1 chk({30'h0, lgo, dgo}, e ? 32'h0 : 32'h3);
            repeat (6) @(posedge hclk);
        end
        rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h8);
        xfer(1'b1, ovd_pkg::IRQ_ENABLE_ADDR, 32'hffffffff);
        rd(ovd_pkg::IRQ_MASK_ADDR, 32'h007c7c7c);
        xfer(1'b1, ovd_pkg::IRQ_DISABLE_ADDR, 32'h0);
        rd(ovd_pkg::IRQ_MASK_ADDR, 32'h007c7c7c);
        xfer(1'b1, ovd_pkg::IRQ_DISABLE_ADDR, 32'h4);
        rd(ovd_pkg::IRQ_MASK_ADDR, 32'h007c7c78);
        xfer(1'b1, ovd_pkg::IRQ_MASK_ADDR, 32'h0);
        rd(ovd_pkg::IRQ_MASK_ADDR, 32'h007c7c78);
        for (int i = 0; i < 15; i++) begin
            ev_q <= 15'h1 << i;
            @(posedge hclk);
            ev_q <= 15'h0;
            @(posedge hclk);
            chk({31'h0, irq}, {31'h0, i != 0});
            rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h4 << ((i / 5) * 8 + i % 5));
            rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        ev_pend = 15'h4000;
        rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h0);
        rd(ovd_pkg::IRQ_STATUS_ADDR, 32'h00400000);
        rd(32'hf80382a8, 32'h0);
        complete_run();
    end
endmodule // tb_top
